// ### core/sysclk_defs.vh
// constants for the system clock select and fast wake-up block
`ifndef SYSCLK_DEFS_VH
`define SYSCLK_DEFS_VH

// ****************************************************************
// register map
// ****************************************************************
`define CTRL_OFFSET          4'h0
`define CTRL_RESET           8'h03
`define CTRL_WMASK           8'hf3

// ****************************************************************
// field positions of system_clock_mode_control
// ****************************************************************
`define HCS_BIT              0
`define IOH_BIT              1
`define HRDY_BIT             2
`define LRDY_BIT             3
`define FWE_BIT              4
`define DIV_LSB              5
`define DIV_MSB              7

// ****************************************************************
// clock_divider_select codes
// ****************************************************************
`define DIV_LOW_A            3'h0
`define DIV_LOW_B            3'h1
`define DIV_64               3'h2
`define DIV_32               3'h3
`define DIV_16               3'h4
`define DIV_8                3'h5
`define DIV_4                3'h6
`define DIV_2                3'h7

// divide ratio as log2 on the output
`define LOG2_1               3'h0
`define LOG2_2               3'h1
`define LOG2_4               3'h2
`define LOG2_8               3'h3
`define LOG2_16              3'h4
`define LOG2_32              3'h5
`define LOG2_64              3'h6

// ****************************************************************
// system clock source, one-hot
// ****************************************************************
`define SRC_NONE             4'h1
`define SRC_HIGH             4'h2
`define SRC_LOW              4'h4
`define SRC_SUB              4'h8

// ****************************************************************
// oscillator types
// ****************************************************************
`define HOSC_CRYSTAL         2'h0
`define HOSC_RC_EXT          2'h1
`define HOSC_RC_INT          2'h2
`define LOSC_CRYSTAL         1'b0
`define LOSC_RC_INT          1'b1

// ****************************************************************
// stabilisation counts in oscillator cycles
// ****************************************************************
`define CNT_W                11
`define CRYSTAL_STABLE       11'h400
`define RC_HIGH_STABLE       11'h010
`define RC_LOW_STABLE        11'h002
`define WAKE_SHORT_CYCLES    2'h2

// ****************************************************************
// bus responses
// ****************************************************************
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ### core/osc_ready_counter.v
// stabilisation counter that raises a ready flag after a number of oscillator cycles
`default_nettype none

module osc_ready_counter #(
	parameter CNT_W = 11
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// oscillator side
	input  wire             osc_enable,
	input  wire             osc_edge,
	input  wire [CNT_W-1:0] target,
	// status
	output reg              ready_reg
);

	reg [CNT_W-1:0] count_reg;

	// a stopped oscillator loses its count, so ready drops at once
	always @(posedge aclk) begin
		if (!aresetn || !osc_enable) begin
			count_reg <= {CNT_W{1'b0}};
			ready_reg <= 1'b0;
		end else if (!ready_reg && osc_edge) begin
			count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			if (count_reg + {{(CNT_W-1){1'b0}}, 1'b1} >= target) begin
				ready_reg <= 1'b1;
			end
		end
	end

endmodule // osc_ready_counter

`default_nettype wire

// ### core/sysclk_select_fast_wakeup.v
// system clock mode control register, oscillator ready flags and halt/wake sequencing
//
// The address map and the AXI4-Lite register port were left to the implementer.
`default_nettype none
`include "sysclk_defs.vh"

module sysclk_select_fast_wakeup (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// oscillator pins, asynchronous
	input  wire        high_osc_clk,
	input  wire        low_osc_clk,
	// configuration and cpu side, same clock
	input  wire [1:0]  high_osc_type,
	input  wire        low_osc_type,
	input  wire        watchdog_enable,
	input  wire        idle_sysclk_keep,
	input  wire        halt_request,
	input  wire        wake_request,
	// clock control outputs
	output reg  [3:0]  sysclk_source_reg,
	output reg  [2:0]  sysclk_div_log2_reg,
	output reg         high_osc_enable_reg,
	output reg         low_osc_enable_reg,
	output reg         cpu_run_reg,
	output reg  [8:0]  state_reg
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam S_RUN        = 9'h001;
	localparam S_IDLE_RUN   = 9'h002;
	localparam S_IDLE_STOP  = 9'h004;
	localparam S_LIGHT_STOP = 9'h008;
	localparam S_DEEP_STOP  = 9'h010;
	localparam S_WAKE_WAIT  = 9'h020;
	localparam S_WAKE_SHORT = 9'h040;
	localparam S_FAST_WAKE  = 9'h080;
	localparam S_FAST_RUN   = 9'h100;

	// ****************************************************************
	// declarations
	// ****************************************************************
	reg  [7:0]         ctrl_reg;
	reg  [3:0]         awaddr_reg;
	reg  [7:0]         wdata_reg;
	reg                wstrb0_reg;
	reg  [1:0]         wake_cnt_reg;
	reg  [2:0]         high_sync_reg;
	reg  [2:0]         low_sync_reg;
	reg  [8:0]         state_next;
	reg  [3:0]         source_next;
	reg  [2:0]         div_next;
	reg  [`CNT_W-1:0]  high_target;
	reg  [`CNT_W-1:0]  low_target;
	wire               high_osc_ready;
	wire               low_osc_ready;
	wire               high_edge;
	wire               low_edge;
	wire               high_src;
	wire               fast_ok;
	wire               wake_edge;
	wire               do_write;
	wire [2:0]         div_code;
	wire [7:0]         ctrl_view;

	assign div_code  = ctrl_reg[`DIV_MSB:`DIV_LSB];
	assign high_src  = ctrl_reg[`HCS_BIT] |
	                   ((div_code != `DIV_LOW_A) && (div_code != `DIV_LOW_B));
	assign ctrl_view = {ctrl_reg[7:4], low_osc_ready, high_osc_ready, ctrl_reg[1:0]};

	// ****************************************************************
	// oscillator synchronisers
	// ****************************************************************
	// stage 0 feeds only stage 1; edges come from stages 1 and 2
	always @(posedge aclk) begin
		if (!aresetn) begin
			high_sync_reg <= 3'h0;
			low_sync_reg  <= 3'h0;
		end else begin
			high_sync_reg <= {high_sync_reg[1:0], high_osc_clk};
			low_sync_reg  <= {low_sync_reg[1:0], low_osc_clk};
		end
	end

	// oscillators must stay below half of aclk or cycles are missed
	assign high_edge = high_sync_reg[1] & ~high_sync_reg[2];
	assign low_edge  = low_sync_reg[1] & ~low_sync_reg[2];

	// ****************************************************************
	// stabilisation counters
	// ****************************************************************
	always @* begin
		if (high_osc_type == `HOSC_CRYSTAL) begin
			high_target = `CRYSTAL_STABLE;
		end else begin
			high_target = `RC_HIGH_STABLE;
		end
		if (low_osc_type == `LOSC_CRYSTAL) begin
			low_target = `CRYSTAL_STABLE;
		end else begin
			low_target = `RC_LOW_STABLE;
		end
	end

	osc_ready_counter #(
		.CNT_W      (`CNT_W)
	) u_high_ready (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.osc_enable (high_osc_enable_reg),
		.osc_edge   (high_edge),
		.target     (high_target),
		.ready_reg  (high_osc_ready)
	);

	osc_ready_counter #(
		.CNT_W      (`CNT_W)
	) u_low_ready (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.osc_enable (low_osc_enable_reg),
		.osc_edge   (low_edge),
		.target     (low_target),
		.ready_reg  (low_osc_ready)
	);

	// ****************************************************************
	// power state machine
	// ****************************************************************
	// substitute clock only runs in light stop and clock-stopped wait
	assign fast_ok = ctrl_reg[`FWE_BIT] & high_src &
	                 (high_osc_type == `HOSC_CRYSTAL) &
	                 ((state_reg == S_LIGHT_STOP) || (state_reg == S_IDLE_STOP));

	assign wake_edge = (state_reg == S_FAST_WAKE) ? low_edge :
	                   (high_src ? high_edge : low_edge);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_RUN: begin
				if (halt_request) begin
					if (ctrl_reg[`IOH_BIT]) begin
						state_next = idle_sysclk_keep ? S_IDLE_RUN : S_IDLE_STOP;
					end else begin
						// watchdog off stops both oscillators
						state_next = watchdog_enable ? S_LIGHT_STOP : S_DEEP_STOP;
					end
				end
			end
			S_IDLE_RUN: begin
				if (wake_request) begin
					state_next = S_WAKE_SHORT;
				end
			end
			S_IDLE_STOP, S_LIGHT_STOP, S_DEEP_STOP: begin
				if (wake_request) begin
					state_next = fast_ok ? S_FAST_WAKE : S_WAKE_WAIT;
				end
			end
			S_WAKE_WAIT: begin
				if (high_src ? high_osc_ready : low_osc_ready) begin
					state_next = S_RUN;
				end
			end
			S_WAKE_SHORT: begin
				if (wake_edge && (wake_cnt_reg + 2'h1 >= `WAKE_SHORT_CYCLES)) begin
					state_next = S_RUN;
				end
			end
			S_FAST_WAKE: begin
				if (wake_edge && (wake_cnt_reg + 2'h1 >= `WAKE_SHORT_CYCLES)) begin
					state_next = S_FAST_RUN;
				end
			end
			S_FAST_RUN: begin
				if (high_osc_ready) begin
					state_next = S_RUN;
				end
			end
			default: begin
				state_next = S_RUN;
			end
		endcase
	end

	// ****************************************************************
	// clock selection
	// ****************************************************************
	always @* begin
		case (div_code)
			`DIV_64: div_next = `LOG2_64;
			`DIV_32: div_next = `LOG2_32;
			`DIV_16: div_next = `LOG2_16;
			`DIV_8:  div_next = `LOG2_8;
			`DIV_4:  div_next = `LOG2_4;
			`DIV_2:  div_next = `LOG2_2;
			default: div_next = `LOG2_1;
		endcase
		if (ctrl_reg[`HCS_BIT] || (state_next == S_FAST_RUN)) begin
			div_next = `LOG2_1;
		end
		case (state_next)
			S_RUN, S_IDLE_RUN, S_WAKE_SHORT: begin
				source_next = high_src ? `SRC_HIGH : `SRC_LOW;
			end
			S_FAST_RUN: begin
				source_next = `SRC_SUB;
			end
			default: begin
				source_next = `SRC_NONE;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg           <= S_RUN;
			wake_cnt_reg        <= 2'h0;
			sysclk_source_reg   <= `SRC_HIGH;
			sysclk_div_log2_reg <= `LOG2_1;
			high_osc_enable_reg <= 1'b1;
			low_osc_enable_reg  <= 1'b1;
			cpu_run_reg         <= 1'b1;
		end else begin
			state_reg           <= state_next;
			sysclk_source_reg   <= source_next;
			sysclk_div_log2_reg <= div_next;
			cpu_run_reg         <= (state_next == S_RUN) || (state_next == S_FAST_RUN);
			// high oscillator stops in stop, clock-stopped wait and on the low clock
			high_osc_enable_reg <= (source_next == `SRC_HIGH) || (state_next == S_WAKE_WAIT && high_src) ||
			                       (state_next == S_FAST_WAKE) || (state_next == S_FAST_RUN);
			low_osc_enable_reg  <= (state_next != S_DEEP_STOP);
			if ((state_reg == S_WAKE_SHORT) || (state_reg == S_FAST_WAKE)) begin
				if (wake_edge) begin
					wake_cnt_reg <= wake_cnt_reg + 2'h1;
				end
			end else begin
				wake_cnt_reg <= 2'h0;
			end
		end
	end

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	// one write in flight; address and data may arrive in either order
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			awaddr_reg    <= 4'h0;
			wdata_reg     <= 8'h00;
			wstrb0_reg    <= 1'b0;
			ctrl_reg      <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata[7:0];
				wstrb0_reg   <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				if ({awaddr_reg[3:2], 2'h0} == `CTRL_OFFSET) begin
					s_axi_bresp <= `RESP_OKAY;
					// ready flags are read-only, only writable bits change
					if (wstrb0_reg) begin
						ctrl_reg <= (ctrl_reg & ~`CTRL_WMASK) | (wdata_reg & `CTRL_WMASK);
					end
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				if ({s_axi_araddr[3:2], 2'h0} == `CTRL_OFFSET) begin
					s_axi_rdata <= {24'h000000, ctrl_view};
					s_axi_rresp <= `RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // sysclk_select_fast_wakeup

`default_nettype wire

// ### testbench/sysclk_select_fast_wakeup_asserts.sv
// port-level checks for the clock select and wake-up block
`default_nettype none
`include "sysclk_defs.vh"

module sysclk_select_fast_wakeup_asserts (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// register bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	// clock control
	input wire logic       wake_request,
	input wire logic [3:0] sysclk_source_reg,
	input wire logic       high_osc_enable_reg,
	input wire logic       low_osc_enable_reg,
	input wire logic       cpu_run_reg,
	input wire logic [8:0] state_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	a_cpu_run: assert property (cpu_run_reg == (state_reg == 9'h001 || state_reg == 9'h100))
		else $error("cpu run flag wrong for state");
	a_deep_low_off: assert property (state_reg == 9'h010 |-> !low_osc_enable_reg)
		else $error("low oscillator on in deep stop");
	a_stop_high_off: assert property ((state_reg & 9'h01c) != 9'h000 |-> !high_osc_enable_reg)
		else $error("high oscillator on while stopped");
	a_fast_sub: assert property (state_reg == 9'h100 |-> sysclk_source_reg == `SRC_SUB)
		else $error("fast run not on substitute clock");
	a_low_high_off: assert property (state_reg == 9'h001 && sysclk_source_reg == `SRC_LOW
		|-> !high_osc_enable_reg) else $error("high oscillator left on");
	a_short_wake: assert property (state_reg == 9'h002 && wake_request |=> state_reg == 9'h040)
		else $error("clock-running wait did not start short wake");
	a_short_done: assert property ($rose(state_reg == 9'h040) |-> ##[1:40] state_reg == 9'h001)
		else $error("short wake too long");

	c_fast: cover property (state_reg == 9'h100);
	c_deep: cover property (state_reg == 9'h010);
	c_short: cover property (state_reg == 9'h040);
endmodule // sysclk_select_fast_wakeup_asserts

bind sysclk_select_fast_wakeup sysclk_select_fast_wakeup_asserts u_asserts (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.wake_request(wake_request), .sysclk_source_reg(sysclk_source_reg),
	.high_osc_enable_reg(high_osc_enable_reg), .low_osc_enable_reg(low_osc_enable_reg),
	.cpu_run_reg(cpu_run_reg), .state_reg(state_reg));
`default_nettype wire

// ### testbench/osc_model.sv
// oscillator pin model for the clock select block
`default_nettype none

module osc_model (
	// clock
	input  wire logic aclk,
	// run requests
	input  wire logic high_en,
	input  wire logic low_en,
	// oscillator pins
	output var  logic high_osc_clk,
	output var  logic low_osc_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase = 2'h0;
	logic       high_q = 1'b0;
	logic       low_q = 1'b0;

	assign high_osc_clk = high_q;
	assign low_osc_clk  = low_q;

	// half period of two cycles keeps both pins below aclk/2; a stopped one stands still
	always @(posedge aclk) begin
		phase <= phase + 2'h1;
		if (high_en && phase[0])
			high_q <= ~high_q;
		if (low_en && !phase[0])
			low_q <= ~low_q;
	end
endmodule // osc_model
`default_nettype wire

// ### testbench/sysclk_select_fast_wakeup_tb.sv
// self-checking bench for the clock select and fast wake-up block
`default_nettype none
`include "sysclk_defs.vh"

module sysclk_select_fast_wakeup_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic [3:0]  s_axi_araddr = 4'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [1:0]  high_osc_type = `HOSC_CRYSTAL;
	logic        watchdog_enable = 1'b1;
	logic        idle_sysclk_keep = 1'b0;
	logic        halt_request = 1'b0;
	logic        wake_request = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        high_osc_clk, low_osc_clk, high_osc_enable_reg, low_osc_enable_reg, cpu_run_reg;
	logic [3:0]  sysclk_source_reg;
	logic [2:0]  sysclk_div_log2_reg;
	logic [8:0]  state_reg;
	int          fails = 0;
	int          num_checks = 0;

	always #20 aclk = ~aclk;

	sysclk_select_fast_wakeup DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .high_osc_clk(high_osc_clk),
		.low_osc_clk(low_osc_clk), .high_osc_type(high_osc_type), .low_osc_type(`LOSC_RC_INT),
		.watchdog_enable(watchdog_enable), .idle_sysclk_keep(idle_sysclk_keep),
		.halt_request(halt_request), .wake_request(wake_request),
		.sysclk_source_reg(sysclk_source_reg), .sysclk_div_log2_reg(sysclk_div_log2_reg),
		.high_osc_enable_reg(high_osc_enable_reg), .low_osc_enable_reg(low_osc_enable_reg),
		.cpu_run_reg(cpu_run_reg), .state_reg(state_reg));

	osc_model oscs (
		.aclk(aclk), .high_en(high_osc_enable_reg), .low_en(low_osc_enable_reg),
		.high_osc_clk(high_osc_clk), .low_osc_clk(low_osc_clk));

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic lim(input int n, input int m);
		if (n >= m) begin
			fails++;
			final_report();
		end
	endtask

	// ****************************************************************
	// register bus master
	// ****************************************************************
	task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		// one idle edge keeps back-to-back calls from driving bready twice at once
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		lim(n, 50);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		lim(n, 50);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, s_axi_rresp});
	endtask

	// poll the control register until the ready flags settle to the expected value
	task automatic wrdy(input logic [7:0] e);
		logic [31:0] d;
		int          n;
		n = 0;
		axr(4'h0, d);
		while (d !== {24'h0, e} && n < 3000) begin
			axr(4'h0, d);
			n++;
		end
		lim(n, 3000);
		chk("ctrl", {24'h0, e}, d);
	endtask

	// ****************************************************************
	// power sequencing helpers
	// ****************************************************************
	task automatic pulse(input logic h);
		@(posedge aclk);
		halt_request <= h;
		wake_request <= !h;
		@(posedge aclk);
		halt_request <= 1'b0;
		wake_request <= 1'b0;
		#1;
	endtask

	task automatic wst(input logic [8:0] s);
		int n;
		n = 0;
		while (state_reg !== s && n < 6000) begin
			@(posedge aclk);
			n++;
		end
		lim(n, 6000);
		chk("state", {23'h0, s}, {23'h0, state_reg});
	endtask

	task automatic wsrc(input logic [3:0] s, input logic [2:0] dv);
		int n;
		n = 0;
		while ((sysclk_source_reg !== s || sysclk_div_log2_reg !== dv) && n < 6000) begin
			@(posedge aclk);
			n++;
		end
		lim(n, 6000);
		chk("source", {28'h0, s}, {28'h0, sysclk_source_reg});
		chk("divide", {29'h0, dv}, {29'h0, sysclk_div_log2_reg});
	endtask

	// halt with given setup, check the held state and flags, wake and follow the way back
	task automatic hw(input logic [7:0] c, input logic k, input logic w, input logic [1:0] t,
			input logic [8:0] st, input logic [7:0] rd, input logic [8:0] wk);
		logic [31:0] d;
		high_osc_type <= t;
		idle_sysclk_keep <= k;
		watchdog_enable <= w;
		axw(4'h0, c, `RESP_OKAY);
		pulse(1'b1);
		chk("halt state", {23'h0, st}, {23'h0, state_reg});
		repeat (2) @(posedge aclk);
		axr(4'h0, d);
		chk("ctrl", {24'h0, rd}, d);
		pulse(1'b0);
		chk("wake state", {23'h0, wk}, {23'h0, state_reg});
		if (wk == 9'h080) begin
			wst(9'h100);
			chk("fast source", {28'h0, `SRC_SUB}, {28'h0, sysclk_source_reg});
		end
		wst(9'h001);
		wsrc(`SRC_HIGH, 3'h0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		logic [31:0] d;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(4'h0, d);
		chk("ctrl", 32'h03, d);
		wrdy(8'h0f);
		axw(4'h4, 8'hff, `RESP_SLVERR);
		axw(4'h0, 8'hf3, `RESP_OKAY);
		axr(4'h0, d);
		chk("ctrl", 32'hff, d);
		for (int c = 7; c >= 0; c--) begin
			axw(4'h0, {c[2:0], 5'h02}, `RESP_OKAY);
			wsrc((c < 2) ? `SRC_LOW : `SRC_HIGH, (c < 2) ? 3'h0 : 3'(8 - c));
		end
		repeat (2) @(posedge aclk);
		chk("high enable", 32'h0, {31'h0, high_osc_enable_reg});
		axr(4'h0, d);
		chk("ctrl", 32'h0a, d);
		axw(4'h0, 8'h03, `RESP_OKAY);
		wsrc(`SRC_HIGH, 3'h0);
		// the high oscillator restarts from cold after the low clock spell
		wrdy(8'h0f);
		hw(8'h03, 1'b1, 1'b1, `HOSC_CRYSTAL, 9'h002, 8'h0f, 9'h040);
		hw(8'h13, 1'b0, 1'b1, `HOSC_CRYSTAL, 9'h004, 8'h1b, 9'h080);
		hw(8'h11, 1'b0, 1'b1, `HOSC_CRYSTAL, 9'h008, 8'h19, 9'h080);
		hw(8'h11, 1'b0, 1'b0, `HOSC_CRYSTAL, 9'h010, 8'h11, 9'h020);
		hw(8'h13, 1'b0, 1'b1, `HOSC_RC_EXT, 9'h004, 8'h1b, 9'h020);
		final_report();
	end
endmodule // sysclk_select_fast_wakeup_tb
`default_nettype wire
